// ===== core/bpn_pkg.sv
package bpn_pkg;

    localparam int PORT_W = 8;
    localparam int NIB_W = 4;
    localparam int IO_ADDR_W = 16;

    // Internal I/O addresses
    localparam logic [IO_ADDR_W-1:0] ADR_PIN_DATA = 16'h0048;
    localparam logic [IO_ADDR_W-1:0] ADR_NIBBLE_TIMING_CONTROL = 16'h004c;
    localparam logic [IO_ADDR_W-1:0] ADR_ALTERNATE_FUNCTION_SELECT = 16'h004d;
    localparam logic [IO_ADDR_W-1:0] ADR_OUTPUT_DRIVE_TYPE = 16'h004e;
    localparam logic [IO_ADDR_W-1:0] ADR_PIN_DIRECTION = 16'h004f;

    // Field positions in nibble_timing_control
    localparam int CTL_LOWER_LSB = 0;
    localparam int CTL_UPPER_LSB = 4;

    // Pin positions in alternate_function_select
    localparam int FN_F_TX_CLOCK = 0;
    localparam int FN_F_RX_CLOCK = 1;
    localparam int FN_F_TX_DATA = 2;
    localparam int FN_E_TX_CLOCK = 4;
    localparam int FN_E_RX_CLOCK = 5;
    localparam int FN_E_TX_DATA = 6;

    // Values after reset
    localparam logic [PORT_W-1:0] RST_PIN_DIRECTION = 8'h00;
    localparam logic [1:0] RST_TIMING_SEL = 2'h0;
    localparam logic [NIB_W-1:0] RST_FINAL_NIBBLE = 4'h0;
    localparam logic [PORT_W-1:0] RST_RD_DATA = 8'h00;
    localparam logic [PORT_W-1:0] RST_SYNC = 8'h00;

    typedef enum logic [1:0] {
        bpn_sel_pclk_half,
        bpn_sel_timer_a1,
        bpn_sel_timer_b1,
        bpn_sel_timer_b2
    } bpn_timing_sel_type;

    typedef struct packed {
        logic [IO_ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [PORT_W-1:0] wdata;
    } bpn_io_req_type;

    typedef struct packed {
        logic timer_b2;
        logic timer_b1;
        logic timer_a1;
        logic pclk_half;
    } bpn_pulses_type;

    typedef struct packed {
        logic e_tx_data;
        logic e_rx_clock;
        logic e_tx_clock;
        logic f_tx_data;
        logic f_rx_clock;
        logic f_tx_clock;
    } bpn_serial_out_type;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } bpn_pads_type;

endpackage : bpn_pkg

// ===== core/bpn_nibble_latch.sv
`timescale 1ns/1ps
module bpn_nibble_latch #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire bpn_pkg::bpn_timing_sel_type sel,
    input wire bpn_pkg::bpn_pulses_type pulses,
    input wire logic [WIDTH-1:0] preload,
    output logic [WIDTH-1:0] final_q
);

    // Refuse a latch that holds no bits
    if (WIDTH < 1) begin : g_width_check
        $error("bpn_nibble_latch: WIDTH must be at least 1");
    end

    logic transfer;
    logic [WIDTH-1:0] final_d;

    // Pick the timing pulse that moves preload into the final register
    assign transfer = (sel == bpn_pkg::bpn_sel_pclk_half) ? pulses.pclk_half :
                      (sel == bpn_pkg::bpn_sel_timer_a1) ? pulses.timer_a1 :
                      (sel == bpn_pkg::bpn_sel_timer_b1) ? pulses.timer_b1 :
                      pulses.timer_b2;
    assign final_d = transfer ? preload : final_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            final_q <= bpn_pkg::RST_FINAL_NIBBLE;
        end else begin
            final_q <= final_d;
        end
    end

endmodule : bpn_nibble_latch

// ===== core/bpn_port.sv
`timescale 1ns/1ps
module bpn_port #(
    parameter int ADDR_W = 16,
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire bpn_pkg::bpn_io_req_type io_req,
    output logic [WIDTH-1:0] io_rd_data,
    output logic io_rd_valid,
    input wire logic [WIDTH-1:0] pad_in,
    output bpn_pkg::bpn_pads_type pads,
    input wire logic timer_a1_pulse,
    input wire logic timer_b1_pulse,
    input wire logic timer_b2_pulse,
    input wire bpn_pkg::bpn_serial_out_type serial_out,
    output logic [WIDTH-1:0] serial_pin_levels
);

    // The decode constants and the pin map are fixed at a byte and a 16-bit address
    if (ADDR_W != bpn_pkg::IO_ADDR_W) begin : g_addr_check
        $error("bpn_port: ADDR_W must match the internal I/O address width");
    end
    if (WIDTH != bpn_pkg::PORT_W) begin : g_width_check
        $error("bpn_port: WIDTH must be 8, the port is byte wide");
    end

    localparam int NW = bpn_pkg::NIB_W;

    // Address decode
    logic sel_data;
    logic sel_ctl;
    logic sel_fn;
    logic sel_drive;
    logic sel_dir;
    logic wr_data;
    logic wr_ctl;
    logic wr_fn;
    logic wr_drive;
    logic wr_dir;
    logic rd_data;

    assign sel_data = (io_req.addr == bpn_pkg::ADR_PIN_DATA);
    assign sel_ctl = (io_req.addr == bpn_pkg::ADR_NIBBLE_TIMING_CONTROL);
    assign sel_fn = (io_req.addr == bpn_pkg::ADR_ALTERNATE_FUNCTION_SELECT);
    assign sel_drive = (io_req.addr == bpn_pkg::ADR_OUTPUT_DRIVE_TYPE);
    assign sel_dir = (io_req.addr == bpn_pkg::ADR_PIN_DIRECTION);

    assign wr_data = io_req.wr && sel_data;
    assign wr_ctl = io_req.wr && sel_ctl;
    assign wr_fn = io_req.wr && sel_fn;
    assign wr_drive = io_req.wr && sel_drive;
    assign wr_dir = io_req.wr && sel_dir;
    assign rd_data = io_req.rd && sel_data;

    // Pin input synchroniser
    logic [WIDTH-1:0] sync1_q;
    logic [WIDTH-1:0] sync2_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= bpn_pkg::RST_SYNC;
            sync2_q <= bpn_pkg::RST_SYNC;
        end else begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
        end
    end

    assign serial_pin_levels = sync2_q;

    // Register file
    logic [WIDTH-1:0] preload_q;
    logic [WIDTH-1:0] preload_d;
    logic [WIDTH-1:0] fn_q;
    logic [WIDTH-1:0] fn_d;
    logic [WIDTH-1:0] drive_q;
    logic [WIDTH-1:0] drive_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    bpn_pkg::bpn_timing_sel_type upper_sel_q;
    bpn_pkg::bpn_timing_sel_type upper_sel_d;
    bpn_pkg::bpn_timing_sel_type lower_sel_q;
    bpn_pkg::bpn_timing_sel_type lower_sel_d;

    assign preload_d = wr_data ? io_req.wdata : preload_q;
    assign fn_d = wr_fn ? io_req.wdata : fn_q;
    assign drive_d = wr_drive ? io_req.wdata : drive_q;
    assign dir_d = wr_dir ? io_req.wdata : dir_q;
    assign upper_sel_d = wr_ctl ?
        bpn_pkg::bpn_timing_sel_type'(io_req.wdata[bpn_pkg::CTL_UPPER_LSB +: 2]) :
        upper_sel_q;
    assign lower_sel_d = wr_ctl ?
        bpn_pkg::bpn_timing_sel_type'(io_req.wdata[bpn_pkg::CTL_LOWER_LSB +: 2]) :
        lower_sel_q;

    // Storage that reset leaves alone
    always_ff @(posedge sys_clk) begin
        preload_q <= preload_d;
        fn_q <= fn_d;
        drive_q <= drive_d;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_q <= bpn_pkg::RST_PIN_DIRECTION;
        end else begin
            dir_q <= dir_d;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_sel_q <= bpn_pkg::bpn_timing_sel_type'(bpn_pkg::RST_TIMING_SEL);
            lower_sel_q <= bpn_pkg::bpn_timing_sel_type'(bpn_pkg::RST_TIMING_SEL);
        end else begin
            upper_sel_q <= upper_sel_d;
            lower_sel_q <= lower_sel_d;
        end
    end

    // Peripheral clock divided by two: a pulse on every second cycle
    logic half_q;
    logic half_d;

    assign half_d = ~half_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            half_q <= 1'b0;
        end else begin
            half_q <= half_d;
        end
    end

    bpn_pkg::bpn_pulses_type pulses;

    assign pulses.pclk_half = half_q;
    assign pulses.timer_a1 = timer_a1_pulse;
    assign pulses.timer_b1 = timer_b1_pulse;
    assign pulses.timer_b2 = timer_b2_pulse;

    // Final output register, one latch per nibble
    logic [WIDTH-1:0] final_out;

    bpn_nibble_latch #(
        .WIDTH(NW)
    ) u_lower (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sel(lower_sel_q),
        .pulses(pulses),
        .preload(preload_q[NW-1:0]),
        .final_q(final_out[NW-1:0])
    );

    bpn_nibble_latch #(
        .WIDTH(NW)
    ) u_upper (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sel(upper_sel_q),
        .pulses(pulses),
        .preload(preload_q[WIDTH-1:NW]),
        .final_q(final_out[WIDTH-1:NW])
    );

    // Alternate outputs by pin; pins 7 and 3 have none and keep port data
    logic [WIDTH-1:0] alt_out;
    logic [WIDTH-1:0] alt_avail;

    assign alt_out[7] = 1'b0;
    assign alt_out[bpn_pkg::FN_E_TX_DATA] = serial_out.e_tx_data;
    assign alt_out[bpn_pkg::FN_E_RX_CLOCK] = serial_out.e_rx_clock;
    assign alt_out[bpn_pkg::FN_E_TX_CLOCK] = serial_out.e_tx_clock;
    assign alt_out[3] = 1'b0;
    assign alt_out[bpn_pkg::FN_F_TX_DATA] = serial_out.f_tx_data;
    assign alt_out[bpn_pkg::FN_F_RX_CLOCK] = serial_out.f_rx_clock;
    assign alt_out[bpn_pkg::FN_F_TX_CLOCK] = serial_out.f_tx_clock;
    assign alt_avail = 8'h77;

    logic [WIDTH-1:0] pin_value;
    logic [WIDTH-1:0] use_alt;

    assign use_alt = fn_q & alt_avail;
    assign pin_value = (use_alt & alt_out) | (~use_alt & final_out);

    // Pad drive: open-drain drives only a low; no drive while an input
    logic [WIDTH-1:0] drive_en;
    logic [WIDTH-1:0] drive_val;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pad
            assign drive_val[i] = dir_q[i] & ~drive_q[i] & pin_value[i];
            assign drive_en[i] = dir_q[i] & (~drive_q[i] | ~pin_value[i]);
        end
    endgenerate

    assign pads.out = drive_val;
    assign pads.oe = drive_en;

    // Read path: only the pin data address reads back, giving the synchronised pin levels; other addresses give zero
    logic [WIDTH-1:0] rd_data_q;
    logic [WIDTH-1:0] rd_data_d;
    logic rd_valid_q;
    logic rd_valid_d;

    assign rd_data_d = rd_data ? sync2_q : (io_req.rd ? bpn_pkg::RST_RD_DATA : rd_data_q);
    assign rd_valid_d = io_req.rd;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= bpn_pkg::RST_RD_DATA;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign io_rd_data = rd_data_q;
    assign io_rd_valid = rd_valid_q;

endmodule : bpn_port

// ===== testbench/bpn_pin_model.sv
`timescale 1ns/1ps
module bpn_pin_model (
    input wire bpn_pkg::bpn_pads_type pads,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] level
);
    // Pins that nobody drives float to the board pull-up
    assign level = (pads.oe & pads.out) | (~pads.oe & ext_en & ext_val) | (~pads.oe & ~ext_en);
endmodule : bpn_pin_model

// ===== testbench/bpn_port_checker.sv
`timescale 1ns/1ps
module bpn_port_checker (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire bpn_pkg::bpn_io_req_type io_req,
    input wire logic [7:0] io_rd_data,
    input wire logic io_rd_valid,
    input wire logic [7:0] pad_in,
    input wire bpn_pkg::bpn_pads_type pads,
    input wire logic timer_a1_pulse,
    input wire logic timer_b1_pulse,
    input wire logic timer_b2_pulse,
    input wire bpn_pkg::bpn_serial_out_type serial_out,
    input wire logic [7:0] serial_pin_levels
);
    logic [1:0] up_q;
    logic pin_rd;
    assign pin_rd = io_req.rd && io_req.addr == bpn_pkg::ADR_PIN_DATA;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    rd_valid_a: assert property (io_req.rd |=> io_rd_valid)
        else $error("read not answered");
    valid_pulse_a: assert property (!io_req.rd |=> !io_rd_valid)
        else $error("valid without read");
    rd_hold_a: assert property (!io_req.rd |=> $stable(io_rd_data))
        else $error("read data moved");
    unmapped_rd_a: assert property (io_req.rd && !pin_rd |=> io_rd_data == 8'h00)
        else $error("write-only read not zero");
    pin_read_a: assert property (pin_rd |=> io_rd_data == $past(serial_pin_levels))
        else $error("pin read wrong");
    sync_level_a: assert property (up_q == 2'h3 |-> serial_pin_levels == $past(pad_in, 2))
        else $error("pin levels lag wrong");
    od_low_a: assert property ((pads.out & ~pads.oe) == 8'h00)
        else $error("undriven pin shows high");
    dir_off_a: assert property (io_req.wr && io_req.addr == bpn_pkg::ADR_PIN_DIRECTION
        && io_req.wdata == 8'h00 |=> pads.oe == 8'h00)
        else $error("input pin still driven");
    reset_in_a: assert property ($rose(arst_n) |-> pads.oe == 8'h00)
        else $error("pin driven after reset");
endmodule : bpn_port_checker
bind bpn_port bpn_port_checker chk_u (.sys_clk, .arst_n, .io_req, .io_rd_data, .io_rd_valid,
    .pad_in, .pads, .timer_a1_pulse, .timer_b1_pulse, .timer_b2_pulse, .serial_out,
    .serial_pin_levels);

// ===== testbench/test_byte_port_nibble_timed_outputs.sv
`timescale 1ns/1ps
module test_byte_port_nibble_timed_outputs;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    bpn_pkg::bpn_io_req_type io_req = '0;
    bpn_pkg::bpn_serial_out_type so = '0;
    bpn_pkg::bpn_pads_type pads;
    logic [7:0] rd_data, pad_lvl, spl, dir, od, fn, dat, prev;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [2:0] tmr = 3'h0;
    logic [15:0] e;
    logic [31:0] r;
    logic [31:0] seed = 32'h28;
    logic rd_valid;
    int num_errors = 0;
    int compares = 0;
    always #5 sys_clk = ~sys_clk;
    bpn_port dut_u (.sys_clk, .arst_n, .io_req, .io_rd_data(rd_data), .io_rd_valid(rd_valid),
        .pad_in(pad_lvl), .pads, .timer_a1_pulse(tmr[0]), .timer_b1_pulse(tmr[1]),
        .timer_b2_pulse(tmr[2]), .serial_out(so), .serial_pin_levels(spl));
    bpn_pin_model pin_u (.pads, .ext_en, .ext_val, .level(pad_lvl));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] exp_pads(logic [7:0] d);
        logic [7:0] v;
        v = (d & ~(fn & 8'h77)) | ({1'b0, so[5:3], 1'b0, so[2:0]} & fn & 8'h77);
        return {dir & ~od & v, dir & (~od | ~v)};
    endfunction : exp_pads
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(negedge sys_clk);
        io_req <= '{a, 1'b1, 1'b0, d};
        @(negedge sys_clk);
        io_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [15:0] a, logic [7:0] x);
        @(negedge sys_clk);
        io_req <= '{a, 1'b0, 1'b1, 8'h00};
        @(negedge sys_clk);
        io_req.rd <= 1'b0;
        chk({7'h00, rd_valid, rd_data}, {8'h01, x});
    endtask : rd
    task automatic pulse(logic [2:0] p);
        @(negedge sys_clk);
        tmr <= p;
        @(negedge sys_clk);
        tmr <= 3'h0;
    endtask : pulse
    task automatic cfg();
        wr(bpn_pkg::ADR_ALTERNATE_FUNCTION_SELECT, fn);
        wr(bpn_pkg::ADR_OUTPUT_DRIVE_TYPE, od);
        wr(bpn_pkg::ADR_PIN_DATA, dat);
        wr(16'h0049, ~dat);
        wr(bpn_pkg::ADR_PIN_DIRECTION, dir);
        repeat (3) @(negedge sys_clk);
    endtask : cfg
    task automatic finish_test();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        chk(pads, 16'h0000);
        {dir, od, fn, dat} = 32'hff00_00a5;
        cfg();
        chk(pads, exp_pads(dat));
        // Random pin setups, both nibbles on the divided clock
        repeat (40) begin
            r = rnd();
            {so, od, dir} = r[21:0];
            r = rnd();
            {fn, dat, ext_en, ext_val} = r;
            wr(bpn_pkg::ADR_NIBBLE_TIMING_CONTROL, dat & 8'hcc);
            cfg();
            e = exp_pads(dat);
            chk(pads, e);
            // Driven pins show the pad value, released ones the board or the pull-up
            prev = (e[7:0] & e[15:8]) | (~e[7:0] & ~(ext_en & ~ext_val));
            rd(bpn_pkg::ADR_PIN_DATA, prev);
            rd({14'h0013, r[9:8]}, 8'h00);
        end
        {dir, od, fn} = 24'hff0000;
        cfg();
        for (int s = 1; s < 4; s++) begin
            prev = dat;
            r = rnd();
            dat = r[7:0];
            wr(bpn_pkg::ADR_NIBBLE_TIMING_CONTROL, 8'(s * 17));
            wr(bpn_pkg::ADR_PIN_DATA, dat);
            repeat (3) @(negedge sys_clk);
            pulse(3'h7 & ~(3'h1 << (s - 1)));
            chk(pads, exp_pads(prev));
            pulse(3'h1 << (s - 1));
            chk(pads, exp_pads(dat));
        end
        prev = dat;
        dat = ~dat;
        wr(bpn_pkg::ADR_NIBBLE_TIMING_CONTROL, 8'h03);
        wr(bpn_pkg::ADR_PIN_DATA, dat);
        repeat (3) @(negedge sys_clk);
        chk(pads, exp_pads({dat[7:4], prev[3:0]}));
        // Turning every pin back to an input releases all pads
        dir = 8'h00;
        wr(bpn_pkg::ADR_PIN_DIRECTION, dir);
        chk(pads, 16'h0000);
        finish_test();
    end
endmodule : test_byte_port_nibble_timed_outputs
